// *** tb.sv ***
`timescale 1ns/1ps
`include "vsl_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED at %0t: got %h expected %h", \
  $time, g, e); end end
module tb;
  typedef struct packed {
    logic [8:0] cmd;
    logic [3:0] pcc;
    logic [31:0] vs;
    logic [31:0] vt;
    logic [31:0] vd;
    logic [3:0] cc;
    logic [3:0] co;
  } vsl_row_t;
  logic aclk;
  logic aresetn;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int miscompares = 0;
  int tests_run = 0;
  // Each row presets codes, and carry bit 0 of every lane so a clear shows.
  vsl_row_t rows [14] = '{
    '{9'h000, 4'hc, 32'h0005ffff, 32'h00050001, 32'h0005ffff, 4'h1, 4'h0},
    '{9'h002, 4'h0, 32'h0005ffff, 32'h00050001, 32'h00050001, 4'h2, 4'h0},
    '{9'h003, 4'h0, 32'h0005ffff, 32'h00050001, 32'h0005ffff, 4'h1, 4'h0},
    '{9'h005, 4'h0, 32'h0005ffff, 32'h00050001, 32'h00050001, 4'h2, 4'h0},
    '{9'h004, 4'h4, 32'h0003ff00, 32'h00100010, 32'h0003fff0, 4'hc, 4'h0},
    '{9'h006, 4'h0, 32'h0003ff00, 32'h00100010, 32'h0003ffef, 4'h8, 4'h0},
    '{9'h001, 4'h0, 32'hff000020, 32'h00100010, 32'hfff00020, 4'h1, 4'h0},
    '{9'h007, 4'h1, 32'h11112222, 32'h33334444, 32'h33332222, 4'h1, 4'h3},
    '{9'h008, 4'h0, 32'hf0f0ff00, 32'h0ff00f0f, 32'h00f00f00, 4'h0, 4'h3},
    '{9'h009, 4'h0, 32'hf0f0ff00, 32'h0ff00f0f, 32'hff0ff0ff, 4'h0, 4'h3},
    '{9'h112, 4'h0, 32'h00070007, 32'h00070003, 32'h00070007, 4'h3, 4'h0},
    '{9'h008, 4'h0, 32'h00000000, 32'h0ff00f0f, 32'h00000000, 4'h0, 4'h3},
    '{9'h00a, 4'h0, 32'hfffe0003, 32'h00050004, 32'hfff6000c, 4'h0, 4'h3},
    '{9'h00a, 4'h0, 32'hfffe0003, 32'h00050004, 32'hffec0018, 4'h0, 4'h3}
  };

  vsl_lanes #(.LANES(2)) u_vsl_lanes (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));
  vsl_su_model u_vsl_su_model (.aclk(aclk), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // Free-running 40 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic [1:0] r;
    u_vsl_su_model.wr(a, d, r);
    `CHK(r, er)
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0] r;
    u_vsl_su_model.rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask : rd_chk

  task automatic cmd(input logic [3:0] op);
    wr(`VSL_ADDR_CMD, {28'h0, op});
  endtask : cmd

  task automatic tally_and_finish;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // The whole run needs well under a thousand cycles; this bound cuts a hang.
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish();
  end

  // Main sequence: the table first, then the awkward cases.
  initial begin
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 14; i++) begin
      wr(`VSL_ADDR_CC, {28'h0, rows[i].pcc});
      wr(`VSL_ADDR_CO, 32'h00000003);
      wr(`VSL_ADDR_VS, rows[i].vs);
      wr(`VSL_ADDR_VT, rows[i].vt);
      wr(`VSL_ADDR_CMD, {23'h0, rows[i].cmd});
      rd_chk(`VSL_ADDR_VD, rows[i].vd);
      rd_chk(`VSL_ADDR_CC, {28'h0, rows[i].cc});
      rd_chk(`VSL_ADDR_CO, {28'h0, rows[i].co});
    end
    wr(`VSL_ADDR_ACCSEL, 32'h00000001);
    rd_chk(`VSL_ADDR_ACCLO, 32'hffec0000);
    rd_chk(`VSL_ADDR_ACCHI, 32'h0000ffff);
    // Sum of -17 and 16 is all ones with differing signs.
    wr(`VSL_ADDR_CE, 32'h00000000);
    wr(`VSL_ADDR_VS, 32'hffefffef);
    wr(`VSL_ADDR_VT, 32'h00100010);
    cmd(`VSL_OP_CH);
    rd_chk(`VSL_ADDR_CE, 32'h00000001);
    rd_chk(`VSL_ADDR_VD, 32'hfff0fff0);
    cmd(`VSL_OP_CL);
    rd_chk(`VSL_ADDR_CE, 32'h00000000);
    wr(`VSL_ADDR_CE, 32'h00000001);
    cmd(`VSL_OP_CR);
    rd_chk(`VSL_ADDR_CE, 32'h00000000);
    // Refused places and code register access.
    wr(`VSL_ADDR_VD, 32'h12345678, `VSL_RESP_SLVERR);
    wr(`VSL_ADDR_ACCLO, 32'h12345678, `VSL_RESP_SLVERR);
    rd_chk(8'h80, 32'h00000000, `VSL_RESP_SLVERR);
    wr(`VSL_ADDR_CC, 32'hffffffff);
    rd_chk(`VSL_ADDR_CC, 32'h0000000f);
    // High halves borrow in lane 0; the low compare then follows it.
    wr(`VSL_ADDR_CO, 32'h00000000);
    wr(`VSL_ADDR_VS, 32'h00010001);
    wr(`VSL_ADDR_VT, 32'h00010002);
    cmd(`VSL_OP_SUBC);
    rd_chk(`VSL_ADDR_CO, 32'h00000005);
    wr(`VSL_ADDR_VS, 32'h00050005);
    wr(`VSL_ADDR_VT, 32'h00010001);
    cmd(`VSL_OP_LT);
    cmd(`VSL_OP_MERGE);
    rd_chk(`VSL_ADDR_VD, 32'h00010005);
    rd_chk(`VSL_ADDR_CC, 32'h00000001);
    rd_chk(`VSL_ADDR_CO, 32'h00000000);
    // Plain add takes carry bit 0 of lane 0 as carry in, then clears it.
    wr(`VSL_ADDR_CO, 32'h00000001);
    cmd(`VSL_OP_ADD);
    rd_chk(`VSL_ADDR_VD, 32'h00060007);
    rd_chk(`VSL_ADDR_CO, 32'h00000000);
    cmd(`VSL_OP_NOP);
    rd_chk(`VSL_ADDR_VD, 32'h00060007);
    // Second reset in mid-run returns every flag to zero.
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`VSL_ADDR_CC, 32'h00000000);
    rd_chk(`VSL_ADDR_CO, 32'h00000000);
    rd_chk(`VSL_ADDR_CE, 32'h00000000);
    rd_chk(`VSL_ADDR_VD, 32'h00000000);
    tally_and_finish();
  end
endmodule : tb

// *** vsl_defs.svh ***
`ifndef VSL_DEFS_SVH
`define VSL_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define VSL_ADDR_CMD 8'h00
`define VSL_ADDR_CC 8'h04
`define VSL_ADDR_CO 8'h08
`define VSL_ADDR_CE 8'h0c
`define VSL_ADDR_ACCSEL 8'h10
`define VSL_ADDR_ACCLO 8'h14
`define VSL_ADDR_ACCHI 8'h18
`define VSL_ADDR_VS 8'h20
`define VSL_ADDR_VT 8'h40
`define VSL_ADDR_VD 8'h60

// Command word fields.
`define VSL_CMD_OP_MSB 3
`define VSL_CMD_OP_LSB 0
`define VSL_CMD_EL_MSB 8
`define VSL_CMD_EL_LSB 4
`define VSL_EL_BCAST 4

// Operation codes; codes 4'h1 and 4'h4 were the withdrawn compares.
`define VSL_OP_LT 4'h0
`define VSL_OP_CH 4'h1
`define VSL_OP_EQ 4'h2
`define VSL_OP_NE 4'h3
`define VSL_OP_CL 4'h4
`define VSL_OP_GE 4'h5
`define VSL_OP_CR 4'h6
`define VSL_OP_MERGE 4'h7
`define VSL_OP_AND 4'h8
`define VSL_OP_NAND 4'h9
`define VSL_OP_MADH 4'ha
`define VSL_OP_ADD 4'hb
`define VSL_OP_SUB 4'hc
`define VSL_OP_ADDC 4'hd
`define VSL_OP_SUBC 4'he
`define VSL_OP_NOP 4'hf

// Accumulator alignment and bus answers.
`define VSL_ACC_SHIFT 16
`define VSL_RESP_OKAY 2'h0
`define VSL_RESP_SLVERR 2'h2

`endif

// *** vsl_lanes.sv ***
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "vsl_defs.svh"
// Operation
// - High partial product accumulates at bit 16
// - Selects compare per lane, record codes, write
// - Selects clear the carry-out bits
// - Compare codes usable by merge next cycle
// - Scalar unit reads and writes compare codes
// - Compare code bits stay set until cleared
// - Less-than select sets codes and picks operand
// - Equal select sets codes and picks operand
// - Not-equal select sets codes and picks operand
// - Greater-equal select sets codes, picks operand
// - Withdrawn compare codes now mean clip ops
// - Clip low: three cases, clears clip extension
// - Crimp uses ones complement negation of vt
// - Merge picks vs or vt by code bit
// - Clip high sets codes for upper cases
// - Clip high sets extension on sum minus one
// - Clip high below negated vt clears, outputs
// - AND result goes via accumulator to vd
// - NAND result goes via accumulator to vd
// - Halfword lanes, vt chosen by element field
// - Carry-out set by ADDC and SUBC, cleared by other ops unless merge, AND, NAND, MADH or NOP
// - Flag and accumulator results feed back next cycle
module vsl_lanes #(
  parameter int LANES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  localparam int WORDS = LANES / 2;
  localparam int LW = $clog2(LANES);

  // Merge a write word into an old value under the byte strobes.
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // True when the address falls in a lane-word region of the map.
  function automatic logic in_region(input logic [7:0] a,
                                     input logic [7:0] base);
    return (a[7:5] == base[7:5]) && (int'(a[4:2]) < WORDS);
  endfunction : in_region

  // Sign-extend a lane to 17 bits so negation of -32768 cannot wrap.
  function automatic logic [16:0] sx17(input vsl_pkg::vsl_lane_t v);
    return {v[15], v};
  endfunction : sx17

  // Bus-side state.
  vsl_pkg::vsl_wr_t wr_q;
  logic aw_full_q, w_full_q;
  logic [7:0] waddr_q;
  logic [31:0] wdat_q;
  logic [3:0] wstb_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Datapath state.
  logic [LANES*16-1:0] vs_q, vt_q, vd_q, vd_d;
  logic [LANES*48-1:0] acc_q, acc_d;
  logic [LANES-1:0] cc0_q, cc1_q, co0_q, co1_q;
  logic [LANES-1:0] cc0_d, cc1_d, co0_d, co1_d;
  logic ce_q, ce_d;
  logic [3:0] op_q;
  logic [4:0] el_q;
  logic exec_q;
  logic [LW-1:0] accsel_q;

  // Write channel handshake signals and the read decode result.
  logic aw_take, w_take, do_write, wr_err, aw_full_d, w_full_d;
  vsl_pkg::vsl_wr_t wr_d;
  logic [31:0] rd_d;
  logic rd_err;

  assign aw_take = awvalid && awready_q;
  assign w_take = wvalid && wready_q;
  assign do_write = (wr_q == vsl_pkg::vsl_wr_collect) && aw_full_q && w_full_q;
  assign aw_full_d = do_write ? 1'b0 : (aw_full_q || aw_take);
  assign w_full_d = do_write ? 1'b0 : (w_full_q || w_take);

  // Address and data are caught independently, in either order.
  always_comb begin
    wr_d = wr_q;
    case (wr_q)
      vsl_pkg::vsl_wr_collect: begin
        if (do_write) begin
          wr_d = vsl_pkg::vsl_wr_resp;
        end
      end
      vsl_pkg::vsl_wr_resp: begin
        if (bready) begin
          wr_d = vsl_pkg::vsl_wr_collect;
        end
      end
      default: wr_d = vsl_pkg::vsl_wr_collect;
    endcase
  end

  // Writes to the result and accumulator views are refused.
  assign wr_err = !(waddr_q == `VSL_ADDR_CMD || waddr_q == `VSL_ADDR_CC ||
                    waddr_q == `VSL_ADDR_CO || waddr_q == `VSL_ADDR_CE ||
                    waddr_q == `VSL_ADDR_ACCSEL ||
                    in_region(waddr_q, `VSL_ADDR_VS) ||
                    in_region(waddr_q, `VSL_ADDR_VT));

  // Write channel registers; ready is dropped while a half is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= vsl_pkg::vsl_wr_collect;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `VSL_RESP_OKAY;
      waddr_q <= 8'h00;
      wdat_q <= 32'h00000000;
      wstb_q <= 4'h0;
    end else begin
      wr_q <= wr_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= !aw_full_d && (wr_d == vsl_pkg::vsl_wr_collect);
      wready_q <= !w_full_d && (wr_d == vsl_pkg::vsl_wr_collect);
      if (aw_take) begin
        waddr_q <= awaddr;
      end
      if (w_take) begin
        wdat_q <= wdata;
        wstb_q <= wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_err ? `VSL_RESP_SLVERR : `VSL_RESP_OKAY;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // A command write launches exactly one execute cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_q <= 1'b0;
      op_q <= 4'h0;
      el_q <= 5'h00;
      accsel_q <= '0;
    end else begin
      exec_q <= do_write && (waddr_q == `VSL_ADDR_CMD);
      if (do_write && waddr_q == `VSL_ADDR_CMD && wstb_q[0]) begin
        op_q <= wdat_q[`VSL_CMD_OP_MSB:`VSL_CMD_OP_LSB];
      end
      if (do_write && waddr_q == `VSL_ADDR_CMD && wstb_q[1]) begin
        el_q[4] <= wdat_q[`VSL_CMD_EL_MSB];
      end
      if (do_write && waddr_q == `VSL_ADDR_CMD && wstb_q[0]) begin
        el_q[3:0] <= wdat_q[`VSL_CMD_EL_MSB-1:`VSL_CMD_EL_LSB];
      end
      if (do_write && waddr_q == `VSL_ADDR_ACCSEL) begin
        accsel_q <= wdat_q[LW-1:0];
      end
    end
  end

  // Operand lane words; each word carries two halfword lanes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_q <= '0;
      vt_q <= '0;
    end else if (do_write) begin
      for (int k = 0; k < WORDS; k++) begin
        if (in_region(waddr_q, `VSL_ADDR_VS) && int'(waddr_q[4:2]) == k) begin
          vs_q[k*32 +: 32] <= strb_merge(vs_q[k*32 +: 32], wdat_q, wstb_q);
        end
        if (in_region(waddr_q, `VSL_ADDR_VT) && int'(waddr_q[4:2]) == k) begin
          vt_q[k*32 +: 32] <= strb_merge(vt_q[k*32 +: 32], wdat_q, wstb_q);
        end
      end
    end
  end

  // Per-lane execute. Signals below are scratch for the lane loop.
  logic [16:0] s17, t17, n2, n1, dsum;
  vsl_pkg::vsl_lane_t s, t;
  logic [31:0] prod;
  logic [47:0] acc_n;
  logic lt, eq, ce_set, ce_clr;

  always_comb begin
    vd_d = vd_q;
    acc_d = acc_q;
    cc0_d = cc0_q;
    cc1_d = cc1_q;
    co0_d = co0_q;
    co1_d = co1_q;
    ce_set = 1'b0;
    ce_clr = 1'b0;
    s = 16'h0000;
    t = 16'h0000;
    s17 = 17'h00000;
    t17 = 17'h00000;
    n2 = 17'h00000;
    n1 = 17'h00000;
    dsum = 17'h00000;
    prod = 32'h00000000;
    acc_n = 48'h000000000000;
    lt = 1'b0;
    eq = 1'b0;
    for (int i = 0; i < LANES; i++) begin
      s = vs_q[i*16 +: 16];
      // Broadcast one vt element or pair lane with lane.
      if (el_q[`VSL_EL_BCAST]) begin
        t = vt_q[int'(el_q[LW-1:0])*16 +: 16];
      end else begin
        t = vt_q[i*16 +: 16];
      end
      s17 = sx17(s);
      t17 = sx17(t);
      n2 = 17'h00000 - t17;
      n1 = ~t17;
      // A differing high half decides the compare from the carry bits.
      lt = co1_q[i] ? co0_q[i] : ($signed(s17) < $signed(t17));
      eq = !co1_q[i] && (s == t);
      prod = 32'($signed(s) * $signed(t));
      acc_n = acc_q[i*48 +: 48];
      if (exec_q) begin
        case (op_q)
          `VSL_OP_LT, `VSL_OP_EQ, `VSL_OP_NE, `VSL_OP_GE: begin
            cc1_d[i] = 1'b0;
            case (op_q)
              `VSL_OP_LT: cc0_d[i] = lt;
              `VSL_OP_EQ: cc0_d[i] = eq;
              `VSL_OP_NE: cc0_d[i] = !eq;
              default: cc0_d[i] = !lt;
            endcase
            vd_d[i*16 +: 16] = cc0_d[i] ? s : t;
          end
          `VSL_OP_CL, `VSL_OP_CR, `VSL_OP_CH: begin
            // Clip family; the withdrawn compare codes land here.
            if (op_q == `VSL_OP_CR) begin
              n2 = n1;
            end
            if ($signed(s17) >= $signed(t17)) begin
              cc0_d[i] = 1'b1;
              vd_d[i*16 +: 16] = s;
            end else if ($signed(s17) > $signed(n2)) begin
              cc1_d[i] = 1'b1;
              vd_d[i*16 +: 16] = s;
            end else begin
              vd_d[i*16 +: 16] = n2[15:0];
              if (op_q != `VSL_OP_CH || $signed(s17) < $signed(n2)) begin
                cc0_d[i] = 1'b0;
              end
              if (op_q == `VSL_OP_CH && $signed(s17) < $signed(n2)) begin
                ce_clr = 1'b1;
              end
            end
            if (op_q == `VSL_OP_CH && s[15] != t[15] &&
                16'(s + t) == 16'hffff) begin
              ce_set = 1'b1;
            end
          end
          `VSL_OP_MERGE: begin
            vd_d[i*16 +: 16] = cc0_q[i] ? s : t;
          end
          `VSL_OP_AND, `VSL_OP_NAND: begin
            // Logic results pass through the accumulator.
            acc_n = 48'h000000000000;
            acc_n[31:16] = (op_q == `VSL_OP_AND) ? (s & t) : ~(s & t);
            acc_d[i*48 +: 48] = acc_n;
            vd_d[i*16 +: 16] = acc_n[31:16];
          end
          `VSL_OP_MADH: begin
            acc_n = acc_n + {prod, 16'h0000};
            acc_d[i*48 +: 48] = acc_n;
            vd_d[i*16 +: 16] = acc_n[31:16];
          end
          `VSL_OP_ADD, `VSL_OP_ADDC: begin
            dsum = {1'b0, s} + {1'b0, t} + {16'h0000, co0_q[i]};
            vd_d[i*16 +: 16] = dsum[15:0];
          end
          `VSL_OP_SUB, `VSL_OP_SUBC: begin
            dsum = {1'b0, s} - {1'b0, t} - {16'h0000, co0_q[i]};
            vd_d[i*16 +: 16] = dsum[15:0];
          end
          default: begin
          end
        endcase
        // Carry-out is produced only by the carry ops; merge, AND, NAND, MADH and NOP keep it, other ops clear it.
        if (op_q == `VSL_OP_ADDC || op_q == `VSL_OP_SUBC) begin
          co0_d[i] = dsum[16];
          co1_d[i] = (op_q == `VSL_OP_SUBC) && (dsum[15:0] != 16'h0000);
        end else if (op_q != `VSL_OP_MERGE && op_q != `VSL_OP_AND &&
                     op_q != `VSL_OP_NAND && op_q != `VSL_OP_MADH &&
                     op_q != `VSL_OP_NOP) begin
          co0_d[i] = 1'b0;
          co1_d[i] = 1'b0;
        end
      end
    end
    // Clip low and crimp clear the extension bit; a set beats a clear.
    if (exec_q && (op_q == `VSL_OP_CL || op_q == `VSL_OP_CR)) begin
      ce_d = 1'b0;
    end else begin
      ce_d = (ce_q && !ce_clr) || ce_set;
    end
  end

  // Flag and accumulator state feed straight back to the next op.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vd_q <= '0;
      acc_q <= '0;
      cc0_q <= '0;
      cc1_q <= '0;
      co0_q <= '0;
      co1_q <= '0;
      ce_q <= 1'b0;
    end else if (exec_q) begin
      vd_q <= vd_d;
      acc_q <= acc_d;
      cc0_q <= cc0_d;
      cc1_q <= cc1_d;
      co0_q <= co0_d;
      co1_q <= co1_d;
      ce_q <= ce_d;
    end else if (do_write) begin
      // Move-control writes from the scalar unit.
      if (waddr_q == `VSL_ADDR_CC) begin
        {cc1_q, cc0_q} <= wdat_q[2*LANES-1:0];
      end
      if (waddr_q == `VSL_ADDR_CO) begin
        {co1_q, co0_q} <= wdat_q[2*LANES-1:0];
      end
      if (waddr_q == `VSL_ADDR_CE) begin
        ce_q <= wdat_q[0];
      end
    end
  end

  // Read decode; unmapped offsets answer zero with an error.
  always_comb begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    if (araddr == `VSL_ADDR_CMD) begin
      rd_d[`VSL_CMD_OP_MSB:`VSL_CMD_OP_LSB] = op_q;
      rd_d[`VSL_CMD_EL_MSB:`VSL_CMD_EL_LSB] = el_q;
    end else if (araddr == `VSL_ADDR_CC) begin
      rd_d[2*LANES-1:0] = {cc1_q, cc0_q};
    end else if (araddr == `VSL_ADDR_CO) begin
      rd_d[2*LANES-1:0] = {co1_q, co0_q};
    end else if (araddr == `VSL_ADDR_CE) begin
      rd_d[0] = ce_q;
    end else if (araddr == `VSL_ADDR_ACCSEL) begin
      rd_d[LW-1:0] = accsel_q;
    end else if (araddr == `VSL_ADDR_ACCLO) begin
      rd_d = acc_q[int'(accsel_q)*48 +: 32];
    end else if (araddr == `VSL_ADDR_ACCHI) begin
      rd_d[15:0] = acc_q[int'(accsel_q)*48+32 +: 16];
    end else if (in_region(araddr, `VSL_ADDR_VS)) begin
      rd_d = vs_q[int'(araddr[4:2])*32 +: 32];
    end else if (in_region(araddr, `VSL_ADDR_VT)) begin
      rd_d = vt_q[int'(araddr[4:2])*32 +: 32];
    end else if (in_region(araddr, `VSL_ADDR_VD)) begin
      rd_d = vd_q[int'(araddr[4:2])*32 +: 32];
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read channel: one read outstanding, data registered at the take.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `VSL_RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_d;
      rresp_q <= rd_err ? `VSL_RESP_SLVERR : `VSL_RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Checks on the execute stage and the flag registers.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic pair_q;
  assign pair_q = !el_q[`VSL_EL_BCAST];

  a_sel_clears_co:
    assert property (exec_q && op_q == `VSL_OP_LT |=> co0_q == '0 && co1_q == '0)
    else $error("select left carry-out bits set");
  a_lt_lane0:
    assert property (exec_q && op_q == `VSL_OP_LT && pair_q && co1_q[0] == 1'b0
      |=> cc1_q[0] == 1'b0 &&
          cc0_q[0] == ($signed($past(vs_q[15:0])) < $signed($past(vt_q[15:0]))))
    else $error("less-than code wrong in lane 0");
  a_eq_lane0:
    assert property (exec_q && op_q == `VSL_OP_EQ && pair_q && co1_q[0] == 1'b0
      |=> cc0_q[0] == ($past(vs_q[15:0]) == $past(vt_q[15:0])) &&
          vd_q[15:0] == $past(vt_q[15:0]))
    else $error("equal select wrong in lane 0");
  a_ne_lane0:
    assert property (exec_q && op_q == `VSL_OP_NE && pair_q && co1_q[0] == 1'b0
      |=> cc0_q[0] == ($past(vs_q[15:0]) != $past(vt_q[15:0])))
    else $error("not-equal code wrong in lane 0");
  a_ge_output:
    assert property (exec_q && op_q == `VSL_OP_GE && pair_q && co1_q[0] == 1'b0
      |=> vd_q[15:0] == (($signed($past(vs_q[15:0])) >=
                          $signed($past(vt_q[15:0]))) ?
                         $past(vs_q[15:0]) : $past(vt_q[15:0])))
    else $error("greater-equal output wrong in lane 0");
  a_clip_ce_clear:
    assert property (exec_q && (op_q == `VSL_OP_CL || op_q == `VSL_OP_CR)
      |=> !ce_q)
    else $error("clip low or crimp left extension set");
  a_merge_keeps_cc:
    assert property (exec_q && op_q == `VSL_OP_MERGE && pair_q
      |=> $stable(cc0_q) && $stable(cc1_q) &&
          vd_q[15:0] == (cc0_q[0] ? $past(vs_q[15:0]) : $past(vt_q[15:0])))
    else $error("merge altered codes or chose wrongly");
  a_madh_result:
    assert property (exec_q && op_q == `VSL_OP_MADH && pair_q
      |=> vd_q[15:0] == acc_q[31:16] &&
          acc_q[47:0] == 48'($past(acc_q[47:0]) +
            {32'($signed($past(vs_q[15:0])) * $signed($past(vt_q[15:0]))),
             16'h0000}))
    else $error("multiply-accumulate result not from accumulator bits");
  a_and_result:
    assert property (exec_q && op_q == `VSL_OP_AND && pair_q
      |=> vd_q[15:0] == ($past(vs_q[15:0]) & $past(vt_q[15:0])))
    else $error("and result wrong in lane 0");
  a_cc_sticky:
    assert property (!exec_q && !(do_write && waddr_q == `VSL_ADDR_CC)
      |=> (cc1_q & $past(cc1_q)) == $past(cc1_q))
    else $error("compare code bit fell without a clearing op");
  a_add_consumes_co:
    assert property (exec_q && op_q == `VSL_OP_ADD |=> co0_q == '0)
    else $error("add left carry-out bits set");

  c_clip_high_ext: cover property (exec_q && op_q == `VSL_OP_CH ##1 ce_q);
  c_sel_then_merge: cover property (exec_q && op_q == `VSL_OP_LT
    ##[1:8] exec_q && op_q == `VSL_OP_MERGE);
  c_subc_then_sel: cover property (exec_q && op_q == `VSL_OP_SUBC
    ##[1:8] exec_q && op_q == `VSL_OP_GE);
  c_read_error: cover property (rvalid_q && rresp_q == `VSL_RESP_SLVERR);

endmodule : vsl_lanes

// *** vsl_pkg.sv ***
package vsl_pkg;

  // One halfword lane and one lane accumulator.
  typedef logic [15:0] vsl_lane_t;
  typedef logic [47:0] vsl_acc_t;

  // Write channel sequencing.
  typedef enum logic [0:0] {
    vsl_wr_collect,
    vsl_wr_resp
  } vsl_wr_t;

endpackage : vsl_pkg

// *** vsl_su_model.sv ***
`timescale 1ns/1ps
// Scalar unit stand-in: moves words to and from the lane registers.
module vsl_su_model (
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // Idle bus at time zero; protection and strobes carry no meaning here.
  initial begin
    awvalid = 1'b0;
    awaddr = 8'h00;
    awprot = 3'h0;
    wvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 8'h00;
    arprot = 3'h0;
    rready = 1'b0;
  end

  // Control transfer to the lanes; a taken payload is scrambled so that
  // a slave reading it late sees garbage, not a lucky match.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Control transfer from the lanes.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : vsl_su_model
